// ---- logic/cbi_pkg.sv ----
// Shared constants and types for the processor bus interface controller.
// Assumes one 50 MHz clock and a zero-wait AHB-Lite register port.
package cbi_pkg;

    // Register byte offsets on the AHB-Lite port.
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;
    localparam logic [7:0] REG_PC = 8'h18;
    localparam logic [7:0] REG_SP = 8'h1c;
    localparam logic [7:0] REG_INTINFO = 8'h20;

    // Field positions.
    localparam int CMD_LAST_BIT = 3;
    localparam int CTRL_IFF_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_VBASE_LSB = 8;
    localparam int INFO_RCNT_LSB = 8;

    // Values after reset.
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [7:0] VBASE_RST = 8'h00;
    localparam logic [6:0] RCNT_RST = 7'h00;
    localparam logic [1:0] IMODE_RST = 2'h0;

    // Restart address, opcode prefixes and stack push length.
    localparam logic [15:0] NMI_VECTOR = 16'h0066;
    localparam logic [7:0] PFX_CB = 8'hcb;
    localparam logic [7:0] PFX_DD = 8'hdd;
    localparam logic [7:0] PFX_ED = 8'hed;
    localparam logic [7:0] PFX_FD = 8'hfd;
    localparam logic [1:0] PUSH_BYTES = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_T1 = 3'h1, ST_T2 = 3'h3, ST_T3 = 3'h2,
        ST_T4 = 3'h6, ST_TW = 3'h7, ST_GRANT = 3'h4
    } cbi_state_t;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0, OP_FETCH = 3'h1, OP_MEMRD = 3'h2, OP_MEMWR = 3'h3,
        OP_IORD = 3'h4, OP_IOWR = 3'h5, OP_HALT = 3'h6
    } cbi_op_t;

    typedef enum logic [2:0] {
        CY_FETCH = 3'h0, CY_MRD = 3'h1, CY_MWR = 3'h2, CY_IRD = 3'h3,
        CY_IWR = 3'h4, CY_INTA = 3'h5
    } cbi_cyc_t;

    typedef enum logic [2:0] {
        SRC_CMD = 3'h0, SRC_PREFIX = 3'h1, SRC_NOP = 3'h2, SRC_PUSH = 3'h3, SRC_INTA = 3'h4
    } cbi_src_t;

    typedef struct packed {
        logic mem_request_n_n;
        logic io_request_n_n;
        logic rd_n;
        logic wr_n;
    } cbi_strobe_t;

    typedef struct packed {
        logic [15:0] a;
        logic a_oe;
        logic [7:0] d;
        logic d_oe;
        cbi_strobe_t ctl;
        logic ctl_oe;
        logic m1_n;
        logic refresh_strobe_n_n;
        logic grant_n;
    } cbi_pins_t;

    localparam cbi_pins_t PINS_RST = '{a: 16'h0000, a_oe: 1'h0, d: 8'h00, d_oe: 1'h0,
        ctl: 4'hf, ctl_oe: 1'h0, m1_n: 1'h1, refresh_strobe_n_n: 1'h1, grant_n: 1'h1};

endpackage

// ---- logic/cbi_top.sv ----
// Processor bus interface: runs machine cycles on the external bus on command.
// Assumes memory and I/O answer within the strobes and inputs are synchronous to MCLK.
//
// Chosen here: the placing of the registers and the AHB-Lite slave port.

// How it works
// RL1: Drive a 16-bit address bus and exchange bytes on an 8-bit tri-state bus.
// RL2: I/O cycles put the port number on the low 8 address lines only.
// RL3: Refresh time shows a valid refresh address on the low 7 address lines.
// RL4: Opcode fetch strobe on every fetch, and again for CB/DD/ED/FD prefixed bytes.
// RL5: Acknowledge is I/O request with opcode fetch; plain I/O never with fetch.
// RL6: Keep inserting wait states while the wait input is held low.
// RL7: Memory request only while the address bus holds a valid memory address.
// RL8: I/O request only while the low address half holds a valid port.
// RL9: Peripherals drive the data bus only while the read strobe is low.
// RL10: Write strobe only while valid write data stands on the data bus.
// RL11: During refresh, address bit 7 is zero and the top byte is the vector base.
// RL12: After halt, flag halted and run no-op fetches until an interrupt is taken.
// RL13: Maskable request taken only at instruction end, latch set, no bus request.
// RL14: After taking a maskable request, acknowledge opens the next instruction cycle.
// RL15: Non-maskable input is falling-edge detected, outranks maskable, ignores the latch.
// RL16: Non-maskable restart pushes the program counter and continues at 0x0066.
// RL17: Bus request outranks non-maskable; endless waits delay interrupt recognition.
// RL18: Reset clears counter, enable latch, vector base, refresh count and mode.
// RL19: During reset the buses float, controls are inactive and no refresh runs.
// RL20: On bus request, float buses and tri-state controls when the cycle ends.
// RL21: Grant goes low once the buses and tri-state controls are floating.
// RL22: No refresh while inserting wait states or while the bus is granted.
// RL23: The reset source holds reset low for at least 3 clock cycles.
// RL24: The acknowledged peripheral drives its vector while fetch and I/O strobes are low.
// RL25: The 7-bit refresh counter advances after each refresh cycle.
module cbi_top
    import cbi_pkg::*;
(
    // Clock and reset.
    input wire logic MCLK,
    input wire logic RST_B,
    // AHB-Lite slave port.
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Processor bus.
    output logic [15:0] A_OUT,
    output logic A_OE,
    input wire logic [7:0] D_IN,
    output logic [7:0] D_OUT,
    output logic D_OE,
    output cbi_strobe_t CTL_OUT,
    output logic CTL_OE,
    output logic OPCODE_FETCH_N,
    output logic REFRESH_STROBE_N,
    output logic HALTED_N,
    // Requests from peripherals.
    input wire logic WAIT_N,
    input wire logic INT_N,
    input wire logic NMI_N,
    // Bus hand-over.
    input wire logic BUS_HOLD_REQUEST_N,
    output logic BUS_HOLD_GRANT_N
);

    cbi_state_t state, next_state;
    cbi_cyc_t cyc, start_cyc, n_cyc;
    cbi_src_t src, start_src;
    cbi_op_t cmd_op;
    cbi_pins_t pins, next_pins;
    logic [15:0] cyc_addr, start_addr, n_addr, pc, sp, addr_reg;
    logic [7:0] cyc_wdata, start_data, n_data, wdata_reg, rdata, vector, vbase;
    logic [6:0] rcnt;
    logic [1:0] imode, push_cnt;
    logic start, take_nmi, take_int, take_halt, consume_cmd;
    logic irq_enable_latch, nmi_prev, nmi_pend, halted_n, boundary, prefix_pend;
    logic cmd_pend, cmd_last, is_io, is_m1kind, is_read, capture, cyc_done, busy;
    logic n_m1, n_io, n_wr, n_rd;
    logic ahb_take, ahb_ok, wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rd_val;

    assign is_io = (cyc == CY_IRD) || (cyc == CY_IWR);
    assign is_m1kind = (cyc == CY_FETCH) || (cyc == CY_INTA);
    assign is_read = (cyc == CY_FETCH) || (cyc == CY_MRD) || (cyc == CY_IRD);
    assign capture = ((state == ST_T2) || (state == ST_TW)) && (next_state == ST_T3);
    assign cyc_done = ((state == ST_T3) && !is_m1kind) || (state == ST_T4);
    assign busy = (state != ST_IDLE) || cmd_pend || prefix_pend || (push_cnt != 2'h0);

    // Sequencer: picks the next machine cycle and walks its T-states.
    always_comb begin
        next_state = state;
        start = 1'h0;
        start_cyc = CY_FETCH;
        start_src = SRC_CMD;
        start_addr = pc;
        start_data = wdata_reg;
        take_nmi = 1'h0;
        take_int = 1'h0;
        take_halt = 1'h0;
        consume_cmd = 1'h0;
        unique case (state)
            ST_IDLE: begin
                if (!BUS_HOLD_REQUEST_N) begin
                    next_state = ST_GRANT; // [RL17] [RL20]
                end else if (boundary && nmi_pend) begin
                    take_nmi = 1'h1; // [RL15]
                end else if (boundary && !INT_N && irq_enable_latch) begin
                    take_int = 1'h1; // [RL13]
                    start = 1'h1;
                    start_cyc = CY_INTA; // [RL14]
                    start_src = SRC_INTA;
                end else if (push_cnt != 2'h0) begin
                    start = 1'h1;
                    start_cyc = CY_MWR;
                    start_src = SRC_PUSH;
                    start_addr = sp - 16'h0001; // [RL16]
                    start_data = (push_cnt == PUSH_BYTES) ? pc[15:8] : pc[7:0];
                end else if (prefix_pend) begin
                    start = 1'h1; // [RL4]
                    start_src = SRC_PREFIX;
                end else if (!halted_n) begin
                    start = 1'h1; // [RL12]
                    start_src = SRC_NOP;
                end else if (cmd_pend) begin
                    consume_cmd = 1'h1;
                    start_addr = addr_reg;
                    case (cmd_op)
                        OP_FETCH: begin
                            start = 1'h1;
                            start_addr = pc;
                        end
                        OP_MEMRD: begin
                            start = 1'h1;
                            start_cyc = CY_MRD;
                        end
                        OP_MEMWR: begin
                            start = 1'h1;
                            start_cyc = CY_MWR;
                        end
                        OP_IORD: begin
                            start = 1'h1;
                            start_cyc = CY_IRD;
                        end
                        OP_IOWR: begin
                            start = 1'h1;
                            start_cyc = CY_IWR;
                        end
                        OP_HALT: take_halt = 1'h1;
                        default: take_halt = 1'h0;
                    endcase
                end
                if (start) begin
                    next_state = ST_T1;
                end
            end
            ST_T1: next_state = ST_T2;
            ST_T2: begin
                // I/O and acknowledge cycles always get one automatic wait state.
                if (is_io || (cyc == CY_INTA) || !WAIT_N) begin
                    next_state = ST_TW; // [RL6]
                end else begin
                    next_state = ST_T3;
                end
            end
            ST_TW: next_state = WAIT_N ? ST_T3 : ST_TW; // [RL6] [RL17]
            ST_T3: next_state = is_m1kind ? ST_T4 : ST_IDLE;
            ST_T4: next_state = ST_IDLE;
            ST_GRANT: next_state = BUS_HOLD_REQUEST_N ? ST_IDLE : ST_GRANT;
            default: next_state = ST_IDLE;
        endcase
    end

    // Pin values are computed for the next state so every pin leaves a flop.
    always_comb begin
        n_cyc = start ? start_cyc : cyc;
        n_addr = start ? start_addr : cyc_addr;
        n_data = start ? start_data : cyc_wdata;
        n_m1 = (n_cyc == CY_FETCH) || (n_cyc == CY_INTA);
        n_io = (n_cyc == CY_IRD) || (n_cyc == CY_IWR);
        n_wr = (n_cyc == CY_MWR) || (n_cyc == CY_IWR);
        n_rd = (n_cyc == CY_FETCH) || (n_cyc == CY_MRD) || (n_cyc == CY_IRD);
        next_pins = PINS_RST;
        next_pins.grant_n = (next_state != ST_GRANT); // [RL21]
        next_pins.ctl_oe = (next_state != ST_GRANT); // [RL20]
        if (next_state inside {ST_T1, ST_T2, ST_TW, ST_T3, ST_T4}) begin
            next_pins.a_oe = 1'h1;
            next_pins.a = n_io ? {8'h00, n_addr[7:0]} : n_addr; // [RL1] [RL2]
            if (n_wr && (next_state != ST_T4)) begin
                next_pins.d_oe = 1'h1; // [RL10]
                next_pins.d = n_data;
            end
            if (n_m1 && (next_state inside {ST_T1, ST_T2, ST_TW})) begin
                next_pins.m1_n = 1'h0; // [RL4]
            end
            if (next_state inside {ST_T2, ST_TW}) begin
                next_pins.ctl.mem_request_n_n = n_io || (n_cyc == CY_INTA); // [RL7]
                next_pins.ctl.io_request_n_n = !(n_io || (n_cyc == CY_INTA)); // [RL5] [RL8]
                next_pins.ctl.rd_n = !n_rd; // [RL9]
                next_pins.ctl.wr_n = !n_wr; // [RL10]
            end
            // Refresh only follows a completed fetch or acknowledge cycle, never a wait or a grant.
            if (n_m1 && (next_state inside {ST_T3, ST_T4})) begin
                next_pins.a = {vbase, 1'h0, rcnt}; // [RL3] [RL11] [RL22]
                next_pins.refresh_strobe_n_n = 1'h0;
                next_pins.ctl.mem_request_n_n = (next_state != ST_T3);
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            state <= ST_IDLE;
            cyc <= CY_FETCH;
            src <= SRC_CMD;
            cyc_addr <= 16'h0000;
            cyc_wdata <= 8'h00;
        end else begin
            state <= next_state;
            if (start) begin
                cyc <= start_cyc;
                src <= start_src;
                cyc_addr <= start_addr;
                cyc_wdata <= start_data;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            pins <= PINS_RST; // [RL19]
        end else begin
            pins <= next_pins;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rcnt <= RCNT_RST; // [RL18]
        end else if (state == ST_T4) begin
            rcnt <= rcnt + 7'h01; // [RL25]
        end
    end

    // Program counter and stack pointer; hardware updates override software.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            pc <= PC_RST; // [RL18]
            sp <= SP_RST;
            push_cnt <= 2'h0;
        end else begin
            if (wr_pend && (wr_addr == REG_PC)) begin
                pc <= HWDATA[15:0];
            end
            if (wr_pend && (wr_addr == REG_SP)) begin
                sp <= HWDATA[15:0];
            end
            if (take_nmi) begin
                push_cnt <= PUSH_BYTES;
            end
            if (cyc_done && (src == SRC_PUSH)) begin
                sp <= cyc_addr;
                push_cnt <= push_cnt - 2'h1;
                if (push_cnt == 2'h1) begin
                    pc <= NMI_VECTOR; // [RL16]
                end
            end else if (cyc_done && (cyc == CY_FETCH) && (src != SRC_NOP)) begin
                pc <= pc + 16'h0001;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_enable_latch <= 1'h0; // [RL18]
            imode <= IMODE_RST;
            vbase <= VBASE_RST;
        end else begin
            if (wr_pend && (wr_addr == REG_CTRL)) begin
                irq_enable_latch <= HWDATA[CTRL_IFF_BIT];
                imode <= HWDATA[CTRL_MODE_LSB +: 2];
                vbase <= HWDATA[CTRL_VBASE_LSB +: 8];
            end
            if (take_int) begin
                irq_enable_latch <= 1'h0;
            end
        end
    end

    // A new falling edge in the cycle the pending flag is taken is kept.
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            nmi_prev <= 1'h1;
            nmi_pend <= 1'h0;
        end else begin
            nmi_prev <= NMI_N;
            nmi_pend <= (nmi_prev && !NMI_N) || (nmi_pend && !take_nmi); // [RL15]
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            halted_n <= 1'h1;
            boundary <= 1'h0;
            prefix_pend <= 1'h0;
            cmd_pend <= 1'h0;
            cmd_op <= OP_NONE;
            cmd_last <= 1'h0;
        end else begin
            if (wr_pend && (wr_addr == REG_CMD) && !cmd_pend) begin
                cmd_pend <= 1'h1;
                cmd_op <= cbi_op_t'(HWDATA[2:0]);
                cmd_last <= HWDATA[CMD_LAST_BIT];
            end
            if (consume_cmd) begin
                cmd_pend <= 1'h0;
            end
            if (start || take_nmi) begin
                boundary <= 1'h0;
            end
            if (take_halt) begin
                halted_n <= 1'h0; // [RL12]
                boundary <= 1'h1;
            end
            if (take_nmi || take_int) begin
                halted_n <= 1'h1;
            end
            if (start && (start_src == SRC_PREFIX)) begin
                prefix_pend <= 1'h0;
            end
            if (cyc_done) begin
                if ((src == SRC_CMD) && (cyc == CY_FETCH)
                        && (rdata inside {PFX_CB, PFX_DD, PFX_ED, PFX_FD})) begin
                    prefix_pend <= 1'h1; // [RL4]
                end else if ((src == SRC_CMD) || (src == SRC_PREFIX)) begin
                    boundary <= cmd_last; // [RL13]
                end else if (src == SRC_NOP) begin
                    boundary <= 1'h1; // [RL12]
                end
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            rdata <= 8'h00;
            vector <= 8'h00;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            if (capture && (cyc == CY_INTA)) begin
                vector <= D_IN;
            end else if (capture && is_read) begin
                rdata <= D_IN;
            end
            if (wr_pend && (wr_addr == REG_ADDR)) begin
                addr_reg <= HWDATA[15:0];
            end
            if (wr_pend && (wr_addr == REG_WDATA)) begin
                wdata_reg <= HWDATA[7:0];
            end
        end
    end

    // Zero-wait slave: reads are answered from a flop loaded at the address phase.
    assign ahb_take = HSEL && HTRANS[1] && HREADY;
    assign ahb_ok = (HADDR[31:8] == 24'h000000);

    always_comb begin
        rd_val = 32'h00000000;
        if (ahb_ok) begin
            case (HADDR[7:0])
                REG_CMD: rd_val = {28'h0000000, cmd_last, cmd_op};
                REG_ADDR: rd_val = {16'h0000, addr_reg};
                REG_WDATA: rd_val = {24'h000000, wdata_reg};
                REG_RDATA: rd_val = {24'h000000, rdata};
                REG_STATUS: rd_val = {26'h0000000, prefix_pend, boundary, nmi_pend,
                    !pins.grant_n, !halted_n, busy};
                REG_CTRL: rd_val = {16'h0000, vbase, 5'h00, imode, irq_enable_latch};
                REG_PC: rd_val = {16'h0000, pc};
                REG_SP: rd_val = {16'h0000, sp};
                REG_INTINFO: rd_val = {17'h00000, rcnt, vector};
                default: rd_val = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            wr_pend <= 1'h0;
            wr_addr <= 8'h00;
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'h1;
            HRESP <= 1'h0;
        end else begin
            wr_pend <= ahb_take && HWRITE && ahb_ok;
            wr_addr <= HADDR[7:0];
            if (ahb_take && !HWRITE) begin
                HRDATA <= rd_val;
            end
            HREADYOUT <= 1'h1;
            HRESP <= 1'h0;
        end
    end

    assign A_OUT = pins.a;
    assign A_OE = pins.a_oe;
    assign D_OUT = pins.d;
    assign D_OE = pins.d_oe;
    assign CTL_OUT = pins.ctl;
    assign CTL_OE = pins.ctl_oe;
    assign OPCODE_FETCH_N = pins.m1_n;
    assign REFRESH_STROBE_N = pins.refresh_strobe_n_n;
    assign BUS_HOLD_GRANT_N = pins.grant_n;
    assign HALTED_N = halted_n;

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_B);

    a_mem_request_n_addr: assert property (!CTL_OUT.mem_request_n_n |-> (A_OE && CTL_OE)) // [RL7]
        else $error("memory request without a driven address");
    a_io_port_low: assert property ((!CTL_OUT.io_request_n_n && OPCODE_FETCH_N)
        |-> (A_OE && (A_OUT[15:8] == 8'h00))) // [RL2] [RL8]
        else $error("I/O cycle drives the upper address byte");
    a_inta_only: assert property ((!CTL_OUT.io_request_n_n && !OPCODE_FETCH_N)
        |-> (cyc == CY_INTA) && CTL_OUT.rd_n && CTL_OUT.wr_n) // [RL5]
        else $error("I/O transfer during opcode fetch");
    a_refresh_addr: assert property (!REFRESH_STROBE_N |-> (A_OUT[15:8] == vbase)
        && !A_OUT[7] && (A_OUT[6:0] == rcnt)) // [RL3] [RL11]
        else $error("wrong refresh address");
    a_write_data: assert property (!CTL_OUT.wr_n |-> (D_OE && (D_OUT == cyc_wdata))) // [RL10]
        else $error("write strobe without write data");
    a_wait_hold: assert property ((state == ST_TW) && !WAIT_N
        |=> (state == ST_TW) && REFRESH_STROBE_N) // [RL6] [RL22]
        else $error("wait state not held");
    a_grant_float: assert property (!BUS_HOLD_GRANT_N
        |-> !A_OE && !D_OE && !CTL_OE && REFRESH_STROBE_N) // [RL21] [RL22]
        else $error("grant while bus still driven");
    a_grant_at_end: assert property ((state == ST_IDLE) && !BUS_HOLD_REQUEST_N
        |=> !BUS_HOLD_GRANT_N) // [RL20] [RL17]
        else $error("bus not released after cycle end");
    a_refresh_step: assert property ((state == ST_T4) |=> (rcnt == $past(rcnt) + 7'h01)) // [RL25]
        else $error("refresh counter did not advance");
    a_nmi_restart: assert property (cyc_done && (src == SRC_PUSH) && (push_cnt == 2'h1)
        |=> (pc == NMI_VECTOR) && (push_cnt == 2'h0)) // [RL16]
        else $error("no restart at the non-maskable vector");
    a_int_accept: assert property (take_int |-> irq_enable_latch && boundary
        && BUS_HOLD_REQUEST_N && !nmi_pend) // [RL13] [RL15]
        else $error("maskable request taken illegally");
    a_int_ack_next: assert property (take_int
        |=> (state == ST_T1) ##1 (!CTL_OUT.io_request_n_n && !OPCODE_FETCH_N)) // [RL14]
        else $error("acknowledge did not follow acceptance");

endmodule

// ---- bench/cbi_far_model.sv ----
// Far-side memory and I/O model answering the processor bus, 256 bytes deep.
// Assumes it sees the design pins directly; SLOW sets wait states per access.
module cbi_far_model
    import cbi_pkg::*;
(
    // Processor bus.
    input wire logic MCLK,
    input wire logic [15:0] A_OUT,
    input wire cbi_strobe_t CTL_OUT,
    input wire logic CTL_OE,
    input wire logic [7:0] D_OUT,
    input wire logic [1:0] SLOW,
    input wire logic OPCODE_FETCH_N,
    output logic [7:0] D_IN,
    output logic WAIT_N
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    logic [1:0] wcnt = 2'h0;
    wire act = CTL_OE && !(CTL_OUT.mem_request_n_n && CTL_OUT.io_request_n_n) && !(CTL_OUT.rd_n && CTL_OUT.wr_n);
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        mem[0] = PFX_CB;
    end
    assign WAIT_N = !(act && wcnt < SLOW);
    // A released bus shows a changing pattern so stale data cannot pass as good.
    // The acknowledging peripheral answers with a fixed vector of our own choosing.
    assign D_IN = (act && !CTL_OUT.rd_n) ? mem[A_OUT[7:0]] :
        (!CTL_OUT.io_request_n_n && !OPCODE_FETCH_N) ? 8'hc9 : ~last;
    always @(posedge MCLK) begin
        last <= D_IN;
        wcnt <= act ? wcnt + 2'h1 : 2'h0;
        if (act && !CTL_OUT.wr_n) mem[A_OUT[7:0]] <= D_OUT;
    end
endmodule

// ---- bench/cbi_top_tb_top.sv ----
// Self-checking bench for the processor bus interface controller.
// Assumes the package and the far-side model are compiled first.
module cbi_top_tb_top
    import cbi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic MCLK = 1'b0, RST_B = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, NMI_N = 1'b1;
    logic BUS_HOLD_REQUEST_N = 1'b1, rd_phase = 1'b0, INT_N = 1'b1;
    logic [1:0] HTRANS = 2'h0, slow = 2'h0;
    logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, rv = '0, rng = 32'h00013d89;
    logic [15:0] A_OUT;
    logic [7:0] D_IN, D_OUT, port = 8'h00, vb = 8'h00;
    cbi_strobe_t CTL_OUT;
    logic HREADYOUT, HRESP, A_OE, D_OE, CTL_OE, OPCODE_FETCH_N, REFRESH_STROBE_N;
    logic HALTED_N, WAIT_N, BUS_HOLD_GRANT_N;
    int err_total = 0, check_count = 0, cyc = 0, m1_falls = 0;
    logic [31:0] q[$];
    initial forever #10 MCLK = ~MCLK;
    cbi_top cbi_top_i (.MCLK, .RST_B, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
        .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .A_OUT, .A_OE, .D_IN, .D_OUT, .D_OE,
        .CTL_OUT, .CTL_OE, .OPCODE_FETCH_N, .REFRESH_STROBE_N, .HALTED_N, .WAIT_N,
        .INT_N, .NMI_N, .BUS_HOLD_REQUEST_N, .BUS_HOLD_GRANT_N);
    cbi_far_model cbi_far_model_i (.MCLK, .A_OUT, .CTL_OUT, .CTL_OE, .D_OUT, .SLOW(slow),
        .OPCODE_FETCH_N, .D_IN, .WAIT_N);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic note, input logic [31:0] exp);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= a;
        HWRITE <= w;
        do @(posedge MCLK); while (!HREADYOUT);
        HTRANS <= 2'h0;
        HWDATA <= d;
        rd_phase <= note;
        if (note) q.push_back(exp);
        do @(posedge MCLK); while (!HREADYOUT);
        rv = HRDATA;
        rd_phase <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, 32'(a), d, 1'b0, '0);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, '0, 1'b1, exp);
    endtask
    task automatic idle();
        for (int i = 0; i < 50; i++) begin
            ahb(1'b0, 32'(REG_STATUS), '0, 1'b0, '0);
            if (rv[0] === 1'b0 && rv[5] === 1'b0) break;
        end
    endtask
    always @(posedge MCLK) if (rd_phase && HREADYOUT) check(HRDATA, q.pop_front());
    always @(negedge OPCODE_FETCH_N) if (RST_B) m1_falls++;
    always @(negedge MCLK) if (RST_B && CTL_OE) begin
        if (!CTL_OUT.mem_request_n_n && REFRESH_STROBE_N) check(A_OE, 1'b1);
        if (!CTL_OUT.wr_n) check(D_OE, 1'b1);
        if (!REFRESH_STROBE_N) check(A_OUT[15:7], {vb, 1'b0});
        if (!CTL_OUT.io_request_n_n && OPCODE_FETCH_N) check(A_OUT[7:0], port);
        if (!WAIT_N || !BUS_HOLD_GRANT_N) check(REFRESH_STROBE_N, 1'b1);
    end
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge MCLK);
        check({A_OE, D_OE, CTL_OE, CTL_OUT, REFRESH_STROBE_N, BUS_HOLD_GRANT_N, HALTED_N,
            OPCODE_FETCH_N}, 11'h0ff);
        RST_B <= 1'b1;
        @(posedge MCLK);
        rd(32'(REG_CTRL), 32'h0);
        rd(32'(REG_PC), 32'(PC_RST));
        rd(32'h100, 32'h0);
        wr(REG_CMD, 32'h9);
        idle();
        check(m1_falls, 2);
        rd(32'(REG_PC), 32'h2);
        rd(32'(REG_INTINFO), 32'h200);
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            slow <= rng[1:0];
            port = rng[15:8] | 8'h01;
            vb = rng[23:16];
            wr(REG_CTRL, {16'h0, vb, 8'h0});
            wr(REG_WDATA, 32'(rng[31:24]));
            wr(REG_ADDR, {16'h0, rng[31:24], port});
            wr(REG_CMD, 32'(2 + k % 4) | 32'h8);
            idle();
            if (k % 2 == 0) rd(32'(REG_RDATA), 32'(cbi_far_model_i.mem[port]));
            else check(cbi_far_model_i.mem[port], rng[31:24]);
        end
        BUS_HOLD_REQUEST_N <= 1'b0;
        for (int i = 0; i < 20 && BUS_HOLD_GRANT_N; i++) @(negedge MCLK);
        check({A_OE, D_OE, CTL_OE, BUS_HOLD_GRANT_N}, 4'h0);
        @(posedge MCLK);
        BUS_HOLD_REQUEST_N <= 1'b1;
        @(posedge MCLK);
        wr(REG_CMD, 32'h6);
        for (int i = 0; i < 40 && HALTED_N; i++) @(negedge MCLK);
        check(HALTED_N, 1'b0);
        @(posedge MCLK);
        NMI_N <= 1'b0;
        for (int i = 0; i < 40 && rv !== 32'h66; i++) ahb(1'b0, 32'(REG_PC), '0, 1'b0, '0);
        check(rv, 32'h66);
        @(negedge MCLK);
        check(HALTED_N, 1'b1);
        check({cbi_far_model_i.mem[8'hff], cbi_far_model_i.mem[8'hfe]}, 32'h2);
        @(posedge MCLK);
        rd(32'(REG_SP), 32'hfffe);
        wr(REG_CTRL, {16'h0, vb, 8'h1});
        INT_N <= 1'b0;
        wr(REG_CMD, 32'h9);
        for (int i = 0; i < 40 && rv[7:0] !== 8'hc9; i++)
            ahb(1'b0, 32'(REG_INTINFO), '0, 1'b0, '0);
        check(rv[7:0], 8'hc9);
        rd(32'(REG_CTRL), {16'h0, vb, 8'h0});
        test_done();
    end
endmodule
